// >>> pkg/clock_select_defines.vh
`ifndef CLOCK_SELECT_DEFINES_VH
`define CLOCK_SELECT_DEFINES_VH

// ******************************************************
// Register offsets
// ******************************************************
`define ADDR_SYSCLK_CTRL   4'h0
`define ADDR_FASTOSC_CTRL  4'h1
`define ADDR_SLOWXTAL_CTRL 4'h2
`define ADDR_PIN_CTRL      4'h3

// ******************************************************
// Field positions
// ******************************************************
`define DIVSEL_MSB      7
`define DIVSEL_LSB      5
`define FASTSEL_BIT     3
`define SLOWSEL_BIT     2
`define RCFREQ_MSB      3
`define RCFREQ_LSB      2
`define RCREADY_BIT     1
`define XTALREADY_BIT   1
`define XTALON_BIT      0
`define SELGOOD_BIT     4

// ******************************************************
// Reset values and codes
// ******************************************************
`define DIVSEL_RESET    3'h0
`define DIVSEL_SLOW     3'h7
`define RCFREQ_RESET    2'h0
`define RCFREQ_4M       2'h0
`define RCFREQ_8M       2'h1
`define RCFREQ_12M      2'h2

// ******************************************************
// Timing counts
// ******************************************************
`define SYS_CLK_KHZ         25000
`define XTAL_STARTUP_US     1000
`define XTAL_STARTUP_CYCLES ((`XTAL_STARTUP_US * `SYS_CLK_KHZ) / 1000)
`define SWITCH_SETTLE_CYC   4
`define FXTAL_GOOD_CHANGES  4
`define FXTAL_STALL_CYC     128

`endif

// >>> rtl/clock_switch_cell.v
`timescale 1ns/1ps
// ******************************************************
// Glitch-free two-input clock switch
// ******************************************************
module clock_switch_cell (
  input  wire sys_rst,   // Asynchronous reset, active high
  input  wire clkA,      // Clock chosen when selB is low
  input  wire clkB,      // Clock chosen when selB is high
  input  wire selB,      // Selection, stable level
  output wire clkOut     // Switched clock
);

  reg  aSync1_ff;
  reg  aSync2_ff;
  reg  bSync1_ff;
  reg  bSync2_ff;

  // Each side enables only after the other side's gate is closed,
  // sampled on its own falling edge so no runt pulse can appear
  always @(negedge clkA or posedge sys_rst) begin
    if (sys_rst) begin
      aSync1_ff <= 1'b1;
      aSync2_ff <= 1'b1;
    end else begin
      aSync1_ff <= ~selB & ~bSync2_ff;
      aSync2_ff <= aSync1_ff;
    end
  end

  // Second branch of the break-before-make pair
  always @(negedge clkB or posedge sys_rst) begin
    if (sys_rst) begin
      bSync1_ff <= 1'b0;
      bSync2_ff <= 1'b0;
    end else begin
      bSync1_ff <= selB & ~aSync2_ff;
      bSync2_ff <= bSync1_ff;
    end
  end

  assign clkOut = (clkA & aSync2_ff) | (clkB & bSync2_ff);

endmodule // clock_switch_cell

// >>> rtl/system_clock_source_select.v
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "clock_select_defines.vh"

module system_clock_source_select #(
  parameter XTAL_START_CYC = `XTAL_STARTUP_CYCLES  // Slow crystal start-up
) (
  input  wire        sys_clk,         // 25 MHz control clock
  input  wire        sys_rst,         // Asynchronous reset, active high
  input  wire [3:0]  regAddr,         // Register address
  input  wire [7:0]  regWrData,       // Write data
  input  wire        regWr,           // Write strobe
  input  wire        regRd,           // Read strobe
  output reg  [7:0]  regRdData,       // Read data, cycle after strobe
  input  wire        extFastCrystal,  // Fast crystal oscillator clock
  input  wire        intFastOsc4m,    // Fast RC at 4 MHz
  input  wire        intFastOsc8m,    // Fast RC at 8 MHz
  input  wire        intFastOsc12m,   // Fast RC at 12 MHz
  input  wire        extSlowCrystal,  // 32.768 kHz crystal clock
  input  wire        intSlowOsc,      // 32 kHz RC clock
  output wire        sysClk,          // Selected system clock
  output wire        fastClk,         // Fast clock to peripherals
  output wire        slowClk,         // Slow clock to peripherals
  output wire        wdtClk,          // Watchdog clock source
  output wire        timeBaseClk,     // Time-base clock source
  output wire [1:0]  rcFreqSel,       // Fast RC trim selection
  output wire        slowCrystalOn,   // Slow crystal oscillator enable
  output wire        slowCrystalPins, // Slow crystal pins owned by osc
  output wire        fastCrystalPins  // Fast crystal pins owned by osc
);

  // ******************************************************
  // Control registers
  // ******************************************************
  reg  [2:0]  divSel_ff;
  reg         fastSourceSel_ff;
  reg         slowSourceSel_ff;
  reg  [1:0]  rcFreqSel_ff;
  reg         slowCrystalOn_ff;
  reg         slowPinOsc_ff;
  reg  [31:0] xtalCnt_ff;
  reg         xtalReady_ff;
  reg         rcReady_ff;
  reg  [2:0]  rcSettle_ff;
  reg  [1:0]  prevRcFreq_ff;

  // Terminal counts trimmed to their counters' widths on purpose
  localparam integer RC_SETTLE_CNT  = `SWITCH_SETTLE_CYC - 1;
  localparam [2:0]   RC_SETTLE_LAST = RC_SETTLE_CNT[2:0];
  localparam integer FX_GOOD_CNT    = `FXTAL_GOOD_CHANGES - 1;
  localparam [2:0]   FX_GOOD_LAST   = FX_GOOD_CNT[2:0];
  localparam integer FX_STALL_CNT   = `FXTAL_STALL_CYC - 1;
  localparam [7:0]   FX_STALL_LAST  = FX_STALL_CNT[7:0];

  // Software writes
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      divSel_ff        <= `DIVSEL_RESET;
      fastSourceSel_ff <= 1'b0;
      slowSourceSel_ff <= 1'b0;
      rcFreqSel_ff     <= `RCFREQ_RESET;
      slowCrystalOn_ff <= 1'b0;
      slowPinOsc_ff    <= 1'b0;
    end else if (regWr) begin
      if (regAddr == `ADDR_SYSCLK_CTRL) begin
        divSel_ff        <= regWrData[`DIVSEL_MSB:`DIVSEL_LSB];
        fastSourceSel_ff <= regWrData[`FASTSEL_BIT];
        slowSourceSel_ff <= regWrData[`SLOWSEL_BIT];
      end else if (regAddr == `ADDR_FASTOSC_CTRL) begin
        rcFreqSel_ff <= regWrData[`RCFREQ_MSB:`RCFREQ_LSB];
      end else if (regAddr == `ADDR_SLOWXTAL_CTRL) begin
        slowCrystalOn_ff <= regWrData[`XTALON_BIT];
      end else if (regAddr == `ADDR_PIN_CTRL) begin
        slowPinOsc_ff <= regWrData[0];
      end
    end
  end

  // Slow crystal start-up timer; restarts whenever enable drops
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      xtalCnt_ff   <= 32'h0;
      xtalReady_ff <= 1'b0;
    end else if (!slowCrystalOn_ff) begin
      xtalCnt_ff   <= 32'h0;
      xtalReady_ff <= 1'b0;
    end else if (!xtalReady_ff) begin
      if (xtalCnt_ff >= XTAL_START_CYC - 1) begin
        xtalReady_ff <= 1'b1;
      end else begin
        xtalCnt_ff <= xtalCnt_ff + 32'h1;
      end
    end
  end

  // Fast RC settles a few cycles after a frequency change
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rcSettle_ff   <= 3'h0;
      rcReady_ff    <= 1'b0;
      prevRcFreq_ff <= `RCFREQ_RESET;
    end else begin
      prevRcFreq_ff <= rcFreqSel_ff;
      if (prevRcFreq_ff != rcFreqSel_ff) begin
        rcSettle_ff <= 3'h0;
        rcReady_ff  <= 1'b0;
      end else if (rcSettle_ff == RC_SETTLE_LAST) begin
        rcReady_ff <= 1'b1;
      end else begin
        rcSettle_ff <= rcSettle_ff + 3'h1;
      end
    end
  end

  // ******************************************************
  // Source choice
  // ******************************************************
  // RC frequency decode; code 11 falls back to 4 MHz, so only codes
  // 01 and 10 ever leave the 4 MHz branch
  function rcHigh;
    input [1:0] code;
    begin
      rcHigh = (code == `RCFREQ_8M) || (code == `RCFREQ_12M);
    end
  endfunction

  wire rcHiClk;
  wire rcClk;

  // The RC taps are unrelated clocks, so a frequency change goes through
  // the same break-before-make cells as a source change: the fast clock
  // pauses for a few RC periods instead of chopping a pulse in half
  clock_switch_cell uRcHiSw (
    .sys_rst (sys_rst),
    .clkA    (intFastOsc8m),
    .clkB    (intFastOsc12m),
    .selB    (rcFreqSel_ff == `RCFREQ_12M),
    .clkOut  (rcHiClk)
  );

  clock_switch_cell uRcSw (
    .sys_rst (sys_rst),
    .clkA    (intFastOsc4m),
    .clkB    (rcHiClk),
    .selB    (rcHigh(rcFreqSel_ff)),
    .clkOut  (rcClk)
  );

  // ******************************************************
  // Fast crystal activity monitor
  // ******************************************************
  // A toggle in the crystal's own domain is carried across by a
  // two-flop synchroniser; each change seen on the control clock
  // proves another crystal period. The toggle changes once a period,
  // so even a 16 MHz crystal changes slower than the 40 ns sample.
  reg        fxTgl_ff;
  reg        fxSync1_ff;
  reg        fxSync2_ff;
  reg        fxSync3_ff;
  reg  [7:0] fxIdle_ff;
  reg  [2:0] fxSeen_ff;
  reg        fxRun_ff;

  always @(posedge extFastCrystal or posedge sys_rst) begin
    if (sys_rst)
      fxTgl_ff <= 1'b0;
    else
      fxTgl_ff <= ~fxTgl_ff;
  end

  // Only the second flop reads the first; the third gives the edge
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fxSync1_ff <= 1'b0;
      fxSync2_ff <= 1'b0;
      fxSync3_ff <= 1'b0;
    end else begin
      fxSync1_ff <= fxTgl_ff;
      fxSync2_ff <= fxSync1_ff;
      fxSync3_ff <= fxSync2_ff;
    end
  end

  wire fxChange = fxSync2_ff ^ fxSync3_ff;

  // Running after a few changes; a long silence revokes it.
  // Limitation: once the switch sits on a crystal that then stops, it
  // cannot hand back, because the cell needs edges of the dead clock
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fxIdle_ff <= 8'h00;
      fxSeen_ff <= 3'h0;
      fxRun_ff  <= 1'b0;
    end else if (fxChange) begin
      fxIdle_ff <= 8'h00;
      if (fxSeen_ff == FX_GOOD_LAST)
        fxRun_ff <= 1'b1;
      else
        fxSeen_ff <= fxSeen_ff + 3'h1;
    end else if (fxIdle_ff == FX_STALL_LAST) begin
      fxSeen_ff <= 3'h0;
      fxRun_ff  <= 1'b0;
    end else begin
      fxIdle_ff <= fxIdle_ff + 8'h1;
    end
  end

  // Fast crystal is only handed the path once it is seen running
  wire fastUseXtal = fastSourceSel_ff & fxRun_ff;

  // Slow crystal path is only taken once it has started up, so the
  // switch never hands over to a dead clock.
  // Limitation: dropping the crystal enable while it drives the path
  // stalls the cell, so software should move to the RC first
  wire slowUseXtal = slowSourceSel_ff & xtalReady_ff;

  // A single select bit per path means one source is always chosen
  clock_switch_cell uFastSw (
    .sys_rst (sys_rst),
    .clkA    (rcClk),
    .clkB    (extFastCrystal),
    .selB    (fastUseXtal),
    .clkOut  (fastClk)
  );

  clock_switch_cell uSlowSw (
    .sys_rst (sys_rst),
    .clkA    (intSlowOsc),
    .clkB    (extSlowCrystal),
    .selB    (slowUseXtal),
    .clkOut  (slowClk)
  );

  // ******************************************************
  // Divider on the fast clock
  // ******************************************************
  reg  [5:0] divCnt_ff;

  always @(posedge fastClk or posedge sys_rst) begin
    if (sys_rst)
      divCnt_ff <= 6'h0;
    else
      divCnt_ff <= divCnt_ff + 6'h1;
  end

  // Divided clock picked by code; tap bits toggle glitch-free only
  // at counter wrap, so the change is also synchronised below.
  // The code is a three-bit word from the control clock: it is only
  // taken when two successive synchronised samples agree, so a word
  // caught mid-change is never applied
  reg  [2:0] divSelFast1_ff;
  reg  [2:0] divSelFast2_ff;
  reg  [2:0] divSelFast3_ff;
  reg  [2:0] divSelUse_ff;

  always @(posedge fastClk or posedge sys_rst) begin
    if (sys_rst) begin
      divSelFast1_ff <= `DIVSEL_RESET;
      divSelFast2_ff <= `DIVSEL_RESET;
      divSelFast3_ff <= `DIVSEL_RESET;
      divSelUse_ff   <= `DIVSEL_RESET;
    end else begin
      divSelFast1_ff <= divSel_ff;
      divSelFast2_ff <= divSelFast1_ff;
      divSelFast3_ff <= divSelFast2_ff;
      if (divCnt_ff == 6'h3f && divSelFast2_ff == divSelFast3_ff)
        divSelUse_ff <= divSelFast3_ff;
    end
  end

  reg divClk;

  always @* begin
    case (divSelUse_ff)
      3'h0:    divClk = fastClk;
      3'h1:    divClk = divCnt_ff[0];
      3'h2:    divClk = divCnt_ff[1];
      3'h3:    divClk = divCnt_ff[2];
      3'h4:    divClk = divCnt_ff[3];
      3'h5:    divClk = divCnt_ff[4];
      3'h6:    divClk = divCnt_ff[5];
      default: divClk = divCnt_ff[5];
    endcase
  end

  // Final fast or slow choice, live changes allowed
  // The cell waits on both clocks, so no runt pulse leaks out
  clock_switch_cell uSysSw (
    .sys_rst (sys_rst),
    .clkA    (divClk),
    .clkB    (slowClk),
    .selB    (divSel_ff == `DIVSEL_SLOW),
    .clkOut  (sysClk)
  );

  // ******************************************************
  // Clock routing and pin ownership
  // ******************************************************
  assign wdtClk          = slowClk;
  assign timeBaseClk     = slowClk;
  assign rcFreqSel       = rcFreqSel_ff;
  assign slowCrystalOn   = slowCrystalOn_ff;
  assign slowCrystalPins = slowPinOsc_ff;
  assign fastCrystalPins = fastSourceSel_ff;

  // ******************************************************
  // Read port
  // ******************************************************
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      if (regAddr == `ADDR_SYSCLK_CTRL)
        regRdData <= {divSel_ff, 1'b0, fastSourceSel_ff,
                      slowSourceSel_ff, 2'h0};
      else if (regAddr == `ADDR_FASTOSC_CTRL)
        regRdData <= {4'h0, rcFreqSel_ff, rcReady_ff, 1'b0};
      else if (regAddr == `ADDR_SLOWXTAL_CTRL)
        regRdData <= {6'h00, xtalReady_ff, slowCrystalOn_ff};
      else if (regAddr == `ADDR_PIN_CTRL)
        regRdData <= {7'h00, slowPinOsc_ff};
      else
        regRdData <= 8'h00;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // system_clock_source_select

// >>> tb/osc_sources.sv
`timescale 1ns/1ps
// ******************************************************
// Behavioural oscillators feeding the clock selector
// ******************************************************
module osc_sources #(
  parameter real FAST_XTAL_HALF = 31.25  // Crystal half period, free choice
) (
  input  wire slowCrystalOn,   // Slow crystal enable from the block
  output reg  extFastCrystal,  // Fast crystal clock
  output reg  intFastOsc4m,    // Fast RC 4 MHz
  output reg  intFastOsc8m,    // Fast RC 8 MHz
  output reg  intFastOsc12m,   // Fast RC 12 MHz
  output reg  extSlowCrystal,  // Slow crystal clock
  output reg  intSlowOsc       // Slow RC clock
);
  // All sources start low so reset sees a defined level
  initial begin
    {extFastCrystal, intFastOsc4m, intFastOsc8m} = 3'h0;
    {intFastOsc12m, extSlowCrystal, intSlowOsc} = 3'h0;
  end
  // Free-running sources
  always #(FAST_XTAL_HALF) extFastCrystal = ~extFastCrystal;
  always #(125.0) intFastOsc4m = ~intFastOsc4m;
  always #(62.5) intFastOsc8m = ~intFastOsc8m;
  always #(41.6667) intFastOsc12m = ~intFastOsc12m;
  always #(15625.0) intSlowOsc = ~intSlowOsc;
  // Crystal stands still low while disabled, so a stale edge never leaks
  always begin
    if (slowCrystalOn === 1'b0) begin
      extSlowCrystal = 1'b0;
      @(posedge slowCrystalOn);
    end
    #(15258.789) extSlowCrystal = ~extSlowCrystal;
  end
endmodule // osc_sources

// >>> tb/system_clock_source_select_checker.sv
`timescale 1ns/1ps
// ******************************************************
// Register-side checks on the clock selector
// ******************************************************
module system_clock_source_select_checker #(
  parameter XTAL_START_CYC = 8  // Slow crystal start-up
) (
  input wire       sys_clk,         // Control clock
  input wire       sys_rst,         // Async reset
  input wire [3:0] regAddr,         // Address
  input wire [7:0] regWrData,       // Write data
  input wire       regWr,           // Write strobe
  input wire       regRd,           // Read strobe
  input wire [7:0] regRdData,       // Read data
  input wire [1:0] rcFreqSel,       // RC trim
  input wire       slowCrystalOn,   // Crystal enable
  input wire       slowCrystalPins, // Crystal pin owner
  input wire       fastCrystalPins  // Fast pin owner
);
  reg [15:0] onCnt_ff;  // Cycles with the crystal enabled
  reg [7:0]  sh0_ff;    // Last value written to offset 0
  // Saturates so a long run never wraps back into the start-up window
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      onCnt_ff <= 16'h0;
      sh0_ff   <= 8'h00;
    end else begin
      if (!slowCrystalOn) onCnt_ff <= 16'h0;
      else if (onCnt_ff != 16'hffff) onCnt_ff <= onCnt_ff + 16'h1;
      if (regWr && regAddr == 4'h0) sh0_ff <= regWrData;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_rd_idle; !regRd |=> regRdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmap; regRd && regAddr > 4'h3 |=> regRdData == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_back0; regRd && regAddr == 4'h0 |=>
    regRdData == {sh0_ff[7:5], 1'b0, sh0_ff[3:2], 2'b00}; endproperty
  a_back0: assert property (p_back0) else $error("bad readback 0");
  property p_rcf; regWr && regAddr == 4'h1 |=>
    rcFreqSel == $past(regWrData[3:2]); endproperty
  a_rcf: assert property (p_rcf) else $error("rc select not taken");
  property p_rchold; !(regWr && regAddr == 4'h1) |=> $stable(rcFreqSel);
  endproperty
  a_rchold: assert property (p_rchold) else $error("rc select moved");
  property p_xon; regWr && regAddr == 4'h2 |=>
    slowCrystalOn == $past(regWrData[0]); endproperty
  a_xon: assert property (p_xon) else $error("crystal enable wrong");
  property p_xwait; regRd && regAddr == 4'h2 &&
    onCnt_ff < XTAL_START_CYC - 2 |=> !regRdData[1]; endproperty
  a_xwait: assert property (p_xwait) else $error("crystal ready early");
  property p_pins; regWr && regAddr == 4'h3 |=>
    slowCrystalPins == $past(regWrData[0]); endproperty
  a_pins: assert property (p_pins) else $error("slow pins wrong");
  property p_fpins; regWr && regAddr == 4'h0 |=>
    fastCrystalPins == $past(regWrData[3]); endproperty
  a_fpins: assert property (p_fpins) else $error("fast pins wrong");
  property p_rst; $fell(sys_rst) |-> rcFreqSel == 2'h0 &&
    !slowCrystalOn && !fastCrystalPins && !slowCrystalPins; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
endmodule // system_clock_source_select_checker

bind system_clock_source_select system_clock_source_select_checker
  #(.XTAL_START_CYC(XTAL_START_CYC)) chk_u (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .rcFreqSel(rcFreqSel), .slowCrystalOn(slowCrystalOn),
  .slowCrystalPins(slowCrystalPins), .fastCrystalPins(fastCrystalPins));

// >>> tb/tb_system_clock_source_select.sv
`timescale 1ns/1ps
module tb_system_clock_source_select;
  reg        sys_clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  reg  [3:0] regAddr = 4'h0;
  reg  [7:0] regWrData = 8'h00, rdVal;
  wire [7:0] regRdData;
  wire [1:0] rcFreqSel;
  wire       fx, r4, r8, r12, sx, sr, sysClk, fastClk, slowClk, wdtClk;
  wire       timeBaseClk, slowCrystalOn, slowCrystalPins, fastCrystalPins;
  reg  [2:0] probeSel = 3'h0, d;
  reg  [1:0] rc;
  integer    failures = 0, check_count = 0, cycles = 0, seed = 32'h1078, i;
  wire probe = probeSel == 3'h0 ? sysClk : probeSel == 3'h1 ? fastClk :
               probeSel == 3'h2 ? slowClk : probeSel == 3'h3 ? wdtClk :
               timeBaseClk;
  always #20 sys_clk = ~sys_clk;
  osc_sources osc_u (.slowCrystalOn(slowCrystalOn), .extFastCrystal(fx),
    .intFastOsc4m(r4), .intFastOsc8m(r8), .intFastOsc12m(r12),
    .extSlowCrystal(sx), .intSlowOsc(sr));
  system_clock_source_select #(.XTAL_START_CYC(8)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .extFastCrystal(fx), .intFastOsc4m(r4),
    .intFastOsc8m(r8), .intFastOsc12m(r12), .extSlowCrystal(sx),
    .intSlowOsc(sr), .sysClk(sysClk), .fastClk(fastClk), .slowClk(slowClk),
    .wdtClk(wdtClk), .timeBaseClk(timeBaseClk), .rcFreqSel(rcFreqSel),
    .slowCrystalOn(slowCrystalOn), .slowCrystalPins(slowCrystalPins),
    .fastCrystalPins(fastCrystalPins));
  // Divided fast clock period in ns for a source and divide code
  function integer expSys(input [2:0] dv, input f, input [1:0] r);
    real fp;
    begin
      fp = f ? 62.5 : r == 2'h1 ? 125.0 : r == 2'h2 ? 83.3334 : 250.0;
      expSys = $rtoi(fp * (1 << dv) + 0.5);
    end
  endfunction
  task finish_test;
    begin
      if (failures == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task check(input [95:0] nm, input [31:0] e, input [31:0] g, input integer t);
    begin
      check_count = check_count + 1;
      if (t == 0 ? g !== e : (^g === 1'bx || g > e + t || g + t < e)) begin
        failures = failures + 1;
        $display("[FAIL] %0s expected %0d seen %0d", nm, e, g);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    begin
      @(posedge sys_clk);
      regWr <= 1'b1; regAddr <= a; regWrData <= v;
      @(posedge sys_clk);
      regWr <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge sys_clk);
      regRd <= 1'b1; regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 rdVal = regRdData;
    end
  endtask
  // Skips edges while a switch settles, then times one full period
  task period(input [2:0] w, input integer e);
    realtime t0;
    begin
      probeSel = w;
      repeat (3) @(posedge probe);
      t0 = $realtime;
      @(posedge probe);
      check("period", e, $rtoi($realtime - t0 + 0.5), 2);
    end
  endtask
  // Hang guard well above the expected run length
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 80000) begin
      failures = failures + 1;
      finish_test;
    end
  end
  initial begin
    // Held past two slow RC edges so every switch cell clears
    repeat (1600) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    for (i = 0; i < 4; i = i + 1) begin
      rd(i);
      check("reset", i == 1 ? 2 : 0, rdVal, 0);
    end
    for (i = 0; i < 4; i = i + 1) begin
      d = $random(seed);
      wr(4'h4 + d, $random(seed));
      rd(4'h4 + d);
      check("unmapped", 0, rdVal, 0);
    end
    period(0, 250);
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h1, i << 2);
      check("rcFreqSel", i, rcFreqSel, 0);
      period(1, expSys(0, 0, i));
    end
    for (i = 0; i < 7; i = i + 1) begin
      d = (i * 3 + 1) % 7;
      rc = $random(seed);
      wr(4'h1, {4'h0, rc, 2'h0});
      wr(4'h0, {d, 5'h00});
      repeat (500) @(posedge sys_clk);  // New code waits for a wrap
      period(0, expSys(d, 0, rc));
    end
    wr(4'h0, 8'h08);
    check("fastPins", 1, fastCrystalPins, 0);
    period(1, expSys(0, 1, 0));
    wr(4'h0, 8'he0);
    check("fastPins", 0, fastCrystalPins, 0);
    period(0, 31250);
    period(3, 31250);
    period(4, 31250);
    wr(4'h0, 8'he4);
    rd(4'h0);
    check("sysCtrl", 8'he4, rdVal, 0);
    period(2, 31250);
    wr(4'h2, 8'h01);
    rd(4'h2);
    check("xtalReady", 1, rdVal, 0);
    for (i = 0; i < 50 && rdVal !== 8'h03; i = i + 1) rd(4'h2);
    check("xtalReady", 3, rdVal, 0);
    period(2, 30518);
    period(0, 30518);
    wr(4'h3, $random(seed) | 1);
    check("slowPins", 1, slowCrystalPins, 0);
    wr(4'h3, 8'h00);
    check("slowPins", 0, slowCrystalPins, 0);
    wr(4'h0, 8'h20);
    period(0, expSys(1, 0, rc));
    finish_test;
  end
endmodule // tb_system_clock_source_select
